// ===== logic/i2c_arb_map.svh
// Constants for the master clock arbitration block: control field positions,
// reset values and bit indices.
// Assumes it is included by bare name from files under logic/.
`ifndef I2C_ARB_MAP_SVH
`define I2C_ARB_MAP_SVH

// ==========================================================================
// Second serial control register fields
`define CTL2_START_BIT 0
`define CTL2_RESTART_BIT 1
`define CTL2_STOP_BIT 2
`define CTL2_RECEIVE_BIT 3
`define CTL2_ACKSEQ_BIT 4
`define CTL2_CMD_MSB 4
`define CTL2_ACKDATA_BIT 5
`define CTL2_ACKSTAT_BIT 6
`define CTL2_SPARE_BIT 7

// ==========================================================================
// Reset values
`define CTL2_RESET 8'h00
`define BUFFER_RESET 8'h00
`define RELOAD_RESET 8'h09
`define COUNTER_RESET 8'h00
`define IDLE_SHIFT 8'hFF
`define ACK_FILL 7'h7F

// ==========================================================================
// Bit indices of a byte sequence
`define LAST_DATA_INDEX 4'h7
`define ACK_INDEX 4'h8

`endif

// ===== logic/i2c_arb_pkg.sv
// Types shared by the master clock arbitration block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package i2c_arb_pkg;

  // ==========================================================================
  // Bus sequences that software can launch
  typedef enum logic [2:0] {
    CMD_START,
    CMD_RESTART,
    CMD_STOP,
    CMD_RECEIVE,
    CMD_ACK,
    CMD_TRANSMIT
  } cmd_t;

  // ==========================================================================
  // Phases of the clock line on the link side
  typedef enum logic [2:0] {
    L_IDLE,
    L_LOW,
    L_RISE,
    L_HIGH,
    L_EDGE
  } link_state_t;

endpackage

`default_nettype wire

// ===== logic/bit_sync.sv
// Two-stage synchroniser for levels and toggles entering a clock domain.
// Assumes each bit is independent or, if grouped, changes one bit at a time.
`default_nettype none

module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst,
  // Asynchronous input and its synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// ===== logic/i2c_master_clock_arbitration.sv
// Master clock arbitration and write protection of a two-wire serial port.
// Software side runs on CLK; the pin side runs on LINK_CLK. Pins are
// open-drain: the testbench resolves each wire from its output enable.
`default_nettype none

`include "i2c_arb_map.svh"

module i2c_master_clock_arbitration
  import i2c_arb_pkg::*;
#(
  parameter int RELOAD_W = 8
) (
  // System clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Link clock
  input wire logic LINK_CLK,
  // Configuration
  input wire logic [RELOAD_W-1:0] BIT_RATE_RELOAD_VALUE,
  // Buffer write
  input wire logic BUF_WRITE,
  input wire logic [7:0] BUF_WDATA,
  // Control two write
  input wire logic CTL2_WRITE,
  input wire logic [7:0] CTL2_WDATA,
  // Collision clear
  input wire logic COLLISION_CLEAR,
  // Status
  output logic [7:0] SERIAL_DATA_BUFFER,
  output logic [7:0] SERIAL_CONTROL_TWO,
  output logic WRITE_COLLISION_FLAG,
  output logic BUSY,
  // Clock pin
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  // Data pin
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  // ==========================================================================
  // Software side state
  cmd_t cmd_hold;
  cmd_t next_cmd;
  logic [7:0] data_hold;
  logic [7:0] next_data;
  logic [RELOAD_W-1:0] reload_hold;
  logic launch_tgl;
  logic done_sync;
  logic done_seen;
  logic done_pulse;
  logic buf_take;
  logic ctl_take;
  logic launch;

  // ==========================================================================
  // Link side state
  link_state_t state;
  link_state_t next_state;
  logic [RELOAD_W-1:0] bit_rate_counter;
  logic [3:0] bit_index;
  logic [7:0] shift;
  logic [7:0] rx_byte;
  logic ack_bit;
  logic done_tgl;
  logic launch_sync;
  logic launch_seen;
  logic start_pulse;
  logic scl_high;
  logic sda_level;
  logic rollover;
  logic is_cond;
  logic last_bit;

  // Lowest set command bit wins when software sets several at once
  function automatic cmd_t decode_cmd(input logic [`CTL2_CMD_MSB:0] bits);
    cmd_t c;
    c = CMD_ACK;
    if (bits[`CTL2_START_BIT]) begin
      c = CMD_START;
    end else if (bits[`CTL2_RESTART_BIT]) begin
      c = CMD_RESTART;
    end else if (bits[`CTL2_STOP_BIT]) begin
      c = CMD_STOP;
    end else if (bits[`CTL2_RECEIVE_BIT]) begin
      c = CMD_RECEIVE;
    end
    return c;
  endfunction

  // ==========================================================================
  // Launch decode
  always_comb begin
    buf_take = BUF_WRITE && !BUSY;
    ctl_take = CTL2_WRITE && !BUSY && !buf_take &&
               (CTL2_WDATA[`CTL2_CMD_MSB:0] != '0);
    launch = buf_take || ctl_take;
    next_cmd = buf_take ? CMD_TRANSMIT : decode_cmd(CTL2_WDATA[`CTL2_CMD_MSB:0]);
    if (buf_take) begin
      next_data = BUF_WDATA;
    end else if (next_cmd == CMD_ACK) begin
      next_data = {CTL2_WDATA[`CTL2_ACKDATA_BIT], `ACK_FILL};
    end else begin
      next_data = `IDLE_SHIFT;
    end
  end

  // Command, data and reload stay frozen while busy, so the link side may
  // read them directly once the launch toggle has crossed.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BUSY <= 1'b0;
      launch_tgl <= 1'b0;
      cmd_hold <= CMD_START;
      data_hold <= `IDLE_SHIFT;
      reload_hold <= RELOAD_W'(`RELOAD_RESET);
    end else if (launch) begin
      BUSY <= 1'b1;
      launch_tgl <= ~launch_tgl;
      cmd_hold <= next_cmd;
      data_hold <= next_data;
      reload_hold <= BIT_RATE_RELOAD_VALUE;
    end else if (done_pulse) begin
      BUSY <= 1'b0;
    end
  end

  // ==========================================================================
  // Completion crossing back to the software side
  bit_sync #(
    .W(1)
  ) u_done_sync (
    .clk(CLK),
    .rst(RST),
    .d(done_tgl),
    .q(done_sync)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      done_seen <= 1'b0;
    end else begin
      done_seen <= done_sync;
    end
  end

  assign done_pulse = done_sync != done_seen;

  // ==========================================================================
  // Data buffer and collision flag
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SERIAL_DATA_BUFFER <= `BUFFER_RESET;
    end else if (buf_take) begin
      SERIAL_DATA_BUFFER <= BUF_WDATA;
    end else if (done_pulse && cmd_hold == CMD_RECEIVE) begin
      // Received byte is stable on the link side until the next launch
      SERIAL_DATA_BUFFER <= rx_byte;
    end
  end

  // A buffer write during a sequence only raises the flag; set wins over clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WRITE_COLLISION_FLAG <= 1'b0;
    end else if (BUF_WRITE && BUSY) begin
      WRITE_COLLISION_FLAG <= 1'b1;
    end else if (COLLISION_CLEAR) begin
      WRITE_COLLISION_FLAG <= 1'b0;
    end
  end

  // ==========================================================================
  // Second serial control register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SERIAL_CONTROL_TWO <= `CTL2_RESET;
    end else begin
      if (CTL2_WRITE) begin
        SERIAL_CONTROL_TWO[`CTL2_SPARE_BIT] <= CTL2_WDATA[`CTL2_SPARE_BIT];
        SERIAL_CONTROL_TWO[`CTL2_ACKDATA_BIT] <= CTL2_WDATA[`CTL2_ACKDATA_BIT];
      end
      // Events cannot queue: command bits are only set while idle
      if (ctl_take) begin
        SERIAL_CONTROL_TWO[`CTL2_CMD_MSB:0] <= CTL2_WDATA[`CTL2_CMD_MSB:0];
      end else if (done_pulse) begin
        SERIAL_CONTROL_TWO[`CTL2_CMD_MSB:0] <= '0;
      end
      if (done_pulse && cmd_hold == CMD_TRANSMIT) begin
        SERIAL_CONTROL_TWO[`CTL2_ACKSTAT_BIT] <= ack_bit;
      end
    end
  end

  // ==========================================================================
  // Link side input crossing
  bit_sync #(
    .W(3)
  ) u_link_sync (
    .clk(LINK_CLK),
    .rst(RST),
    .d({launch_tgl, SCL_I, SDA_I}),
    .q({launch_sync, scl_high, sda_level})
  );

  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      launch_seen <= 1'b0;
    end else begin
      launch_seen <= launch_sync;
    end
  end

  assign start_pulse = launch_sync != launch_seen;

  // ==========================================================================
  // Clock phase sequencer
  always_comb begin
    rollover = bit_rate_counter == '0;
    is_cond = (cmd_hold == CMD_START) || (cmd_hold == CMD_RESTART) ||
              (cmd_hold == CMD_STOP);
    unique case (cmd_hold)
      CMD_TRANSMIT: last_bit = bit_index == `ACK_INDEX;
      CMD_RECEIVE: last_bit = bit_index == `LAST_DATA_INDEX;
      default: last_bit = 1'b1;
    endcase
  end

  always_comb begin
    next_state = state;
    unique case (state)
      L_IDLE: begin
        if (start_pulse) begin
          next_state = (cmd_hold == CMD_START) ? L_RISE : L_LOW;
        end
      end
      L_LOW: begin
        if (rollover) begin
          next_state = L_RISE;
        end
      end
      L_RISE: begin
        // A slave holding the clock low stretches this phase
        if (scl_high) begin
          next_state = L_HIGH;
        end
      end
      L_HIGH: begin
        if (rollover) begin
          if (is_cond) begin
            next_state = L_EDGE;
          end else if (last_bit) begin
            next_state = L_IDLE;
          end else begin
            next_state = L_LOW;
          end
        end
      end
      L_EDGE: begin
        if (rollover) begin
          next_state = L_IDLE;
        end
      end
      default: next_state = L_IDLE;
    endcase
  end

  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      state <= L_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Bit-rate counter: counting phases reload on entry, release phase holds
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      bit_rate_counter <= RELOAD_W'(`COUNTER_RESET);
    end else if (next_state != state &&
                 (next_state == L_LOW || next_state == L_HIGH || next_state == L_EDGE)) begin
      bit_rate_counter <= reload_hold;
    end else if (state == L_RISE) begin
      bit_rate_counter <= bit_rate_counter;
    end else if (state != L_IDLE && !rollover) begin
      // High phase runs to zero from a fresh reload whatever the stretch was
      bit_rate_counter <= bit_rate_counter - RELOAD_W'(1);
    end
  end

  // ==========================================================================
  // Bit shifting and sampling
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      bit_index <= '0;
      shift <= `IDLE_SHIFT;
      rx_byte <= '0;
      ack_bit <= 1'b0;
    end else if (state == L_IDLE && start_pulse) begin
      bit_index <= '0;
      shift <= data_hold;
    end else if (state == L_HIGH && rollover) begin
      bit_index <= bit_index + 4'h1;
      shift <= {shift[6:0], 1'b1};
      if (cmd_hold == CMD_RECEIVE) begin
        rx_byte <= {rx_byte[6:0], sda_level};
      end
      if (cmd_hold == CMD_TRANSMIT && bit_index == `ACK_INDEX) begin
        ack_bit <= sda_level;
      end
    end
  end

  // ==========================================================================
  // Pin drive
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      SCL_OE <= 1'b0;
      SCL_O <= 1'b0;
    end else begin
      SCL_O <= 1'b0;
      if (next_state == L_LOW) begin
        SCL_OE <= 1'b1;
      end else if (next_state == L_RISE) begin
        SCL_OE <= 1'b0;
      end else if (state == L_EDGE && next_state == L_IDLE) begin
        SCL_OE <= cmd_hold != CMD_STOP;
      end else if (state == L_HIGH && next_state == L_IDLE) begin
        SCL_OE <= 1'b1;
      end
    end
  end

  // Data changes one link cycle after the clock falls, giving hold time
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      SDA_OE <= 1'b0;
      SDA_O <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
      if (state == L_LOW) begin
        SDA_OE <= (cmd_hold == CMD_STOP) || !shift[7];
      end else if (state == L_HIGH && next_state == L_EDGE) begin
        SDA_OE <= cmd_hold != CMD_STOP;
      end else if (state == L_IDLE && start_pulse && cmd_hold == CMD_START) begin
        SDA_OE <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Completion toggle
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      done_tgl <= 1'b0;
    end else if (state != L_IDLE && next_state == L_IDLE) begin
      done_tgl <= ~done_tgl;
    end
  end

endmodule

`default_nettype wire

// ===== test/i2c_bus_model.sv
// Behavioural model of the other devices on the two-wire bus.
// Assumes open-drain pins with pull-ups; wires are resolved here.
`default_nettype none

module i2c_bus_model (
  // Master pin enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Stretch control from the bench
  input wire logic slow,
  // Resolved wires
  output logic scl,
  output logic sda,
  // Data level at each clock rise, newest in bit 0
  output logic [8:0] bits_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold = 1'b0;

  // ==========
  // Clock stretching
  // A slow device keeps the clock low well past the master's release
  always @(posedge scl_oe) begin
    if (slow) begin
      hold = 1'b1;
      #500;
      hold = 1'b0;
    end
  end

  // Pull-ups win when nobody pulls; no device ever acknowledges
  assign scl = !(scl_oe || hold);
  assign sda = !sda_oe;

  // Receivers sample data on the rising clock, as a slave would
  always @(posedge scl) begin
    bits_seen <= {bits_seen[7:0], sda};
  end
endmodule

`default_nettype wire

// ===== test/i2c_arb_chk.sv
// Concurrent checks on the arbitration block's ports.
// Assumes the pins are fed back as resolved open-drain wire levels.
`default_nettype none

module i2c_arb_chk #(
  parameter int RELOAD_W = 8
) (
  // Clocks and reset
  input wire logic CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  // Software side
  input wire logic [RELOAD_W-1:0] BIT_RATE_RELOAD_VALUE,
  input wire logic BUF_WRITE,
  input wire logic [7:0] BUF_WDATA,
  input wire logic CTL2_WRITE,
  input wire logic COLLISION_CLEAR,
  input wire logic [7:0] SERIAL_DATA_BUFFER,
  input wire logic [7:0] SERIAL_CONTROL_TWO,
  input wire logic WRITE_COLLISION_FLAG,
  input wire logic BUSY,
  // Pins
  input wire logic SCL_I,
  input wire logic SCL_OE,
  input wire logic SCL_O,
  input wire logic SDA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] high_cnt;

  // ==========
  // Length of the current high phase, saturating
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      high_cnt <= 10'h000;
    end else if (!SCL_I) begin
      high_cnt <= 10'h000;
    end else if (high_cnt != 10'h3FF) begin
      high_cnt <= high_cnt + 10'h001;
    end
  end

  // ==========
  // Link side
  a_wait_released: assert property (@(posedge LINK_CLK) disable iff (RST)
    !SCL_OE && !SCL_I |=> !SCL_OE) else $error("clock driven while held low");
  a_high_min: assert property (@(posedge LINK_CLK) disable iff (RST)
    $rose(SCL_OE) |-> high_cnt > 10'(BIT_RATE_RELOAD_VALUE))
    else $error("clock high phase too short");
  a_pins_open: assert property (@(posedge LINK_CLK) disable iff (RST)
    !SCL_O && !SDA_O) else $error("pin driven high");

  // ==========
  // Software side
  a_collision_set: assert property (@(posedge CLK) disable iff (RST)
    BUF_WRITE && BUSY |=> WRITE_COLLISION_FLAG) else $error("collision not flagged");
  a_buffer_kept: assert property (@(posedge CLK) disable iff (RST)
    BUF_WRITE && BUSY && !SERIAL_CONTROL_TWO[3] |=> $stable(SERIAL_DATA_BUFFER))
    else $error("buffer changed by refused write");
  a_buffer_load: assert property (@(posedge CLK) disable iff (RST)
    BUF_WRITE && !BUSY |=> BUSY && SERIAL_DATA_BUFFER == $past(BUF_WDATA))
    else $error("idle buffer write not taken");
  a_cmd_blocked: assert property (@(posedge CLK) disable iff (RST)
    CTL2_WRITE && BUSY |=> (SERIAL_CONTROL_TWO[4:0] & ~$past(SERIAL_CONTROL_TWO[4:0])) == 5'h00)
    else $error("command bit set while busy");
  a_flag_sticky: assert property (@(posedge CLK) disable iff (RST)
    WRITE_COLLISION_FLAG && !COLLISION_CLEAR |=> WRITE_COLLISION_FLAG)
    else $error("collision flag lost");
  a_flag_clear: assert property (@(posedge CLK) disable iff (RST)
    COLLISION_CLEAR && !(BUF_WRITE && BUSY) |=> !WRITE_COLLISION_FLAG)
    else $error("collision flag not cleared");
  a_flag_cause: assert property (@(posedge CLK) disable iff (RST)
    $rose(WRITE_COLLISION_FLAG) |-> $past(BUF_WRITE) && $past(BUSY))
    else $error("collision flag without cause");

  c_refused: cover property (@(posedge CLK) BUF_WRITE && BUSY);
  c_ctl_busy: cover property (@(posedge CLK) CTL2_WRITE && BUSY);
  c_stretch: cover property (@(posedge LINK_CLK) !SCL_OE && !SCL_I);
endmodule

bind i2c_master_clock_arbitration i2c_arb_chk #(.RELOAD_W(RELOAD_W)) i_chk (
  .CLK(CLK), .RST(RST), .LINK_CLK(LINK_CLK),
  .BIT_RATE_RELOAD_VALUE(BIT_RATE_RELOAD_VALUE), .BUF_WRITE(BUF_WRITE),
  .BUF_WDATA(BUF_WDATA), .CTL2_WRITE(CTL2_WRITE), .COLLISION_CLEAR(COLLISION_CLEAR),
  .SERIAL_DATA_BUFFER(SERIAL_DATA_BUFFER), .SERIAL_CONTROL_TWO(SERIAL_CONTROL_TWO),
  .WRITE_COLLISION_FLAG(WRITE_COLLISION_FLAG), .BUSY(BUSY), .SCL_I(SCL_I), .SCL_OE(SCL_OE),
  .SCL_O(SCL_O), .SDA_O(SDA_O)
);

`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the master clock arbitration block.
// Assumes the design under logic/ and the bus model and checker here.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk = 1'b0;
  logic buf_write = 1'b0;
  logic ctl_write = 1'b0;
  logic write_collision_flag_clear = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reload = 8'h03;
  logic [7:0] buf_wdata = 8'h00;
  logic [7:0] ctl_wdata = 8'h00;
  logic [7:0] buf_q, ctl_q;
  logic write_collision_flag, busy, scl_oe, sda_oe, scl, sda;
  logic [8:0] bits_seen;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  i2c_master_clock_arbitration #(.RELOAD_W(8)) i_dut (
    .CLK(clk), .RST(rst), .LINK_CLK(link_clk), .BIT_RATE_RELOAD_VALUE(reload),
    .BUF_WRITE(buf_write), .BUF_WDATA(buf_wdata), .CTL2_WRITE(ctl_write),
    .CTL2_WDATA(ctl_wdata), .COLLISION_CLEAR(write_collision_flag_clear), .SERIAL_DATA_BUFFER(buf_q),
    .SERIAL_CONTROL_TWO(ctl_q), .WRITE_COLLISION_FLAG(write_collision_flag), .BUSY(busy),
    .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe)
  );
  i2c_bus_model i_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .slow(slow), .scl(scl), .sda(sda),
    .bits_seen(bits_seen));

  // ==========
  // Clocks and hang guard
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      close_out();
    end
  end

  // ==========
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_buf(input logic [7:0] d);
    @(posedge clk);
    buf_write <= 1'b1;
    buf_wdata <= d;
    @(posedge clk);
    buf_write <= 1'b0;
    #1;
  endtask
  task automatic wr_ctl(input logic [7:0] d);
    @(posedge clk);
    ctl_write <= 1'b1;
    ctl_wdata <= d;
    @(posedge clk);
    ctl_write <= 1'b0;
    #1;
  endtask
  task automatic clear_flag();
    @(posedge clk);
    write_collision_flag_clear <= 1'b1;
    @(posedge clk);
    write_collision_flag_clear <= 1'b0;
    #1;
    chk({7'h00, write_collision_flag}, 8'h00);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_start();
    wr_ctl(8'h01);
    chk({7'h00, busy}, 8'h01);
    wr_ctl(8'hA6);
    chk({1'b0, ctl_q[7], ctl_q[5], ctl_q[4:0]}, 8'h61);
    wr_buf(8'h77);
    chk(buf_q, 8'h00);
    chk({7'h00, write_collision_flag}, 8'h01);
    wait_idle();
    chk({3'h0, ctl_q[4:0]}, 8'h00);
    chk({7'h00, write_collision_flag}, 8'h01);
    clear_flag();
  endtask

  task automatic t_transmit();
    slow <= 1'b1;
    wr_buf(8'hA5);
    chk(buf_q, 8'hA5);
    wr_buf(8'h3C);
    chk(buf_q, 8'hA5);
    chk({7'h00, write_collision_flag}, 8'h01);
    wr_ctl(8'h1F);
    chk({3'h0, ctl_q[4:0]}, 8'h00);
    wait_idle();
    chk(buf_q, 8'hA5);
    chk({7'h00, write_collision_flag}, 8'h01);
    chk({7'h00, ctl_q[6]}, 8'h01);
    // Eight data bits MSB first, then the released acknowledge bit
    chk(bits_seen[8:1], 8'hA5);
    chk({7'h00, bits_seen[0]}, 8'h01);
    clear_flag();
  endtask

  task automatic t_commands();
    logic [7:0] cmds [4];
    cmds = '{8'h08, 8'h10, 8'h02, 8'h04};
    // A second reload value, so the high-phase check sees the new count
    @(posedge clk);
    reload <= 8'h05;
    foreach (cmds[i]) begin
      slow <= i[0];
      wr_ctl(cmds[i]);
      wr_buf(8'h5A);
      chk({7'h00, write_collision_flag}, 8'h01);
      wait_idle();
      chk({3'h0, ctl_q[4:0]}, 8'h00);
      if (i == 0) begin
        chk(buf_q, 8'hFF);
      end else if (i == 1) begin
        // Acknowledge data 0 must pull the data line during its clock
        chk({7'h00, bits_seen[0]}, 8'h00);
      end
      clear_flag();
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    t_start();
    t_transmit();
    t_commands();
    close_out();
  end
endmodule

`default_nettype wire
